// [pkg/vsd_params.svh]
`ifndef VSD_PARAMS_SVH
`define VSD_PARAMS_SVH

// Register indices; the byte address is four times the index
`define VSD_IDX_VDIP_WIN_CH1 6'h00
`define VSD_IDX_VDIP_THR_CH1 6'h01
`define VSD_IDX_IDROP_WIN_CH1 6'h04
`define VSD_IDX_IDROP_THR_CH1 6'h05
`define VSD_IDX_VDIP_WIN_CH2 6'h08
`define VSD_IDX_VDIP_THR_CH2 6'h09
`define VSD_IDX_IDROP_WIN_CH2 6'h0c
`define VSD_IDX_IDROP_THR_CH2 6'h0d
`define VSD_IDX_STATUS 6'h10
`define VSD_IDX_MASK 6'h11
`define VSD_IDX_LIVE 6'h12

// Field layout and reset values
`define VSD_WIN_BITS 23
`define VSD_THR_BITS 24
`define VSD_WIN_RESET 23'h00_0000
`define VSD_THR_RESET 24'h00_0000
`define VSD_FLAG_RESET 4'h0

`endif

// [pkg/vsd_pkg.sv]
`default_nettype none

package vsd_pkg;

    // Channel order: 0 voltage ch1, 1 current ch1, 2 voltage ch2, 3 current ch2
    typedef logic [3:0][23:0] vsd_samp_t;

    // Sample stream from the measurement path
    typedef struct packed {
        logic valid;
        vsd_samp_t data;
    } vsd_sample_s;

    // APB slave phase
    typedef enum logic [1:0] {
        VSD_ST_IDLE = 2'b01,
        VSD_ST_DONE = 2'b10
    } vsd_apb_e;

endpackage

`default_nettype wire

// [hdl/vsd_detect.sv]
//
// Overview of operation
// (RQ1) Window register sets samples per evaluation
// (RQ2) Zero window disables that channel's detector
// (RQ3) Voltage dip: average magnitude below threshold
// (RQ4) Current drop: average magnitude below threshold
// (RQ5) Threshold is unsigned 24-bit fraction below one
// (RQ6) Window top bit reads zero, 23 bits
// (RQ7) Detection sets sticky per-channel status flag
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vsd_params.svh"

module vsd_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Instantaneous samples
    input wire vsd_pkg::vsd_sample_s sample,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Detector results
    output logic [3:0] dip_live,
    output logic irq
);

    //****************************************************************
    // Helpers
    //****************************************************************

    // Magnitude of a signed 24-bit sample
    function automatic logic [23:0] mag24(input logic [23:0] s);
        mag24 = s[23] ? 24'(~s + 24'h00_0001) : s;
    endfunction

    // Register index from a byte address, with a flag for aligned hits
    function automatic logic [6:0] decode(input logic [7:0] a);
        logic [5:0] idx;
        logic hit;
        idx = a[7:2];
        hit = (a[1:0] == 2'b00) &&
              ((idx == `VSD_IDX_STATUS) || (idx == `VSD_IDX_MASK) ||
               (idx == `VSD_IDX_LIVE) ||
               (idx[5:4] == 2'b00 && idx[1] == 1'b0));
        decode = {hit, idx};
    endfunction

    //****************************************************************
    // Storage
    //****************************************************************

    logic [3:0][`VSD_WIN_BITS-1:0] win;
    logic [3:0][`VSD_THR_BITS-1:0] thr;
    logic [3:0][`VSD_WIN_BITS-1:0] cnt;
    logic [3:0][46:0] acc;
    logic [3:0] done;
    logic [3:0] status;
    logic [3:0] mask;
    vsd_pkg::vsd_apb_e st;

    logic [6:0] dec;
    logic wr_en;
    logic [3:0] last;
    logic [3:0][46:0] next_acc;
    logic [3:0] below;
    logic [3:0] set_flag;
    logic [3:0] clr_flag;

    //****************************************************************
    // Bus decode
    //****************************************************************

    // Address decode and write strobe at the completing edge
    always_comb begin
        dec = decode(paddr);
        wr_en = psel && penable && pready && pwrite && dec[6];
    end

    //****************************************************************
    // APB handshake
    //****************************************************************

    // One wait state: pready rises the cycle after access starts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= vsd_pkg::VSD_ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            case (st)
                vsd_pkg::VSD_ST_IDLE: begin
                    if (psel && penable) begin
                        st <= vsd_pkg::VSD_ST_DONE;
                        pready <= 1'b1;
                        pslverr <= ~dec[6];
                    end
                end
                vsd_pkg::VSD_ST_DONE: begin
                    st <= vsd_pkg::VSD_ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    st <= vsd_pkg::VSD_ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // Read data captured with pready; unmapped reads give zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (st == vsd_pkg::VSD_ST_IDLE && psel && penable) begin
            prdata <= 32'h0000_0000;
            if (dec[6] && !pwrite) begin
                case (dec[5:0])
                    `VSD_IDX_STATUS: prdata <= {28'h000_0000, status};
                    `VSD_IDX_MASK: prdata <= {28'h000_0000, mask};
                    `VSD_IDX_LIVE: prdata <= {28'h000_0000, dip_live};
                    default: begin
                        if (dec[0]) begin
                            prdata <= {8'h00, thr[dec[3:2]]}; // RQ5
                        end else begin
                            prdata <= {9'h000, win[dec[3:2]]}; // RQ6
                        end
                    end
                endcase
            end
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    //****************************************************************
    // Configuration registers
    //****************************************************************

    // Window and threshold per channel
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 4; c++) begin
                win[c] <= `VSD_WIN_RESET; // RQ1
                thr[c] <= `VSD_THR_RESET;
            end
        end else if (wr_en && dec[5:4] == 2'b00) begin
            if (dec[0]) begin
                thr[dec[3:2]] <= pwdata[23:0]; // RQ5
            end else begin
                win[dec[3:2]] <= pwdata[22:0]; // RQ6
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask <= `VSD_FLAG_RESET;
        end else if (wr_en && dec[5:0] == `VSD_IDX_MASK) begin
            mask <= pwdata[3:0];
        end
    end

    //****************************************************************
    // Detectors
    //****************************************************************

    // Window end and averaged comparison as sum*2 < level*count
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            last[c] = sample.valid && (win[c] != `VSD_WIN_RESET) && // RQ2
                      (24'(cnt[c]) + 24'h00_0001 >= 24'(win[c])); // RQ1
            next_acc[c] = acc[c] + 47'(mag24(sample.data[c]));
            below[c] = {next_acc[c], 1'b0} < (48'(thr[c]) * 48'(win[c])); // RQ3 RQ4
        end
    end

    // Sample counters and magnitude accumulators
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 4; c++) begin
                cnt[c] <= `VSD_WIN_RESET;
                acc[c] <= 47'h0000_0000_0000;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (win[c] == `VSD_WIN_RESET) begin
                    cnt[c] <= `VSD_WIN_RESET; // RQ2
                    acc[c] <= 47'h0000_0000_0000;
                end else if (last[c]) begin
                    cnt[c] <= `VSD_WIN_RESET; // RQ1
                    acc[c] <= 47'h0000_0000_0000;
                end else if (sample.valid) begin
                    cnt[c] <= cnt[c] + 23'h00_0001;
                    acc[c] <= next_acc[c];
                end
            end
        end
    end

    // Result of each completed window
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done <= `VSD_FLAG_RESET;
            dip_live <= `VSD_FLAG_RESET;
        end else begin
            done <= last;
            for (int c = 0; c < 4; c++) begin
                if (win[c] == `VSD_WIN_RESET) begin
                    dip_live[c] <= 1'b0; // RQ2
                end else if (last[c]) begin
                    dip_live[c] <= below[c]; // RQ3 RQ4
                end
            end
        end
    end

    //****************************************************************
    // Status and interrupt
    //****************************************************************

    // Sticky flags, write one to clear, set beats clear
    always_comb begin
        set_flag = last & below;
        clr_flag = (wr_en && dec[5:0] == `VSD_IDX_STATUS) ? pwdata[3:0] : 4'h0;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= `VSD_FLAG_RESET;
        end else begin
            status <= (status & ~clr_flag) | set_flag; // RQ7
        end
    end

    // Level interrupt while any unmasked flag is set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~clr_flag) | set_flag) & mask); // RQ7
        end
    end

    //****************************************************************
    // Assertions
    //****************************************************************

    // A window closes only on the sample that reaches the count
    property p_win_count;
        @(posedge clk) disable iff (reset)
        done[0] |-> $past(sample.valid) &&
            ($past(24'(cnt[0])) + 24'h00_0001 == $past(24'(win[0])));
    endproperty
    a_win_count: assert property (p_win_count) else $error("window closed early"); // RQ1

    // A zero window never reports anything
    property p_zero_off;
        @(posedge clk) disable iff (reset)
        (win[1] == `VSD_WIN_RESET) [*3] |-> !done[1] && !dip_live[1];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("disabled channel active"); // RQ2

    // Voltage dip result equals the averaged comparison
    property p_vdip;
        @(posedge clk) disable iff (reset)
        last[0] |=> dip_live[0] == $past(below[0]);
    endproperty
    a_vdip: assert property (p_vdip) else $error("voltage dip result wrong"); // RQ3

    // Current drop result sets its status flag
    property p_idrop;
        @(posedge clk) disable iff (reset)
        (last[1] && below[1]) |=> status[1] && dip_live[1];
    endproperty
    a_idrop: assert property (p_idrop) else $error("current drop missed"); // RQ4

    // Threshold keeps all 24 written bits
    property p_thr;
        @(posedge clk) disable iff (reset)
        (wr_en && dec[5:0] == `VSD_IDX_VDIP_THR_CH2) |=> thr[2] == $past(pwdata[23:0]);
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not stored"); // RQ5

    // Window top bit reads back as zero
    property p_win_top;
        @(posedge clk) disable iff (reset)
        (psel && penable && !pwrite && dec[6] && dec[5:4] == 2'b00 && !dec[0] &&
         st == vsd_pkg::VSD_ST_IDLE) |=> pready && prdata[31:23] == 9'h000;
    endproperty
    a_win_top: assert property (p_win_top) else $error("window top bit set"); // RQ6

    // Flag stays set until cleared and drives the interrupt when unmasked
    property p_sticky;
        @(posedge clk) disable iff (reset)
        (status[3] && !clr_flag[3]) |=> status[3] ##0
            (irq == $past(|(((status & ~clr_flag) | set_flag) & mask)));
    endproperty
    a_sticky: assert property (p_sticky) else $error("status flag lost"); // RQ7

    // Every detection lands in status, even against a clear in the same cycle
    property p_set_wins;
        @(posedge clk) disable iff (reset)
        (|set_flag) |=> ((status & $past(set_flag)) == $past(set_flag));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("detection not flagged"); // RQ7

    // Writing a one clears a flag when no detection arrives with it
    property p_clear;
        @(posedge clk) disable iff (reset)
        (clr_flag[2] && !set_flag[2]) |=> !status[2];
    endproperty
    a_clear: assert property (p_clear) else $error("status flag not cleared"); // RQ7

    // Interrupt follows the unmasked flags in the same cycle, using the previous cycle's mask
    property p_irq;
        @(posedge clk) disable iff (reset)
        1'b1 |=> (irq == |(status & $past(mask)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong"); // RQ7

    // Unmapped or unaligned access answers with an error
    property p_slverr;
        @(posedge clk) disable iff (reset)
        (psel && penable && !pready && !dec[6]) |=> pready && pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("bad address not refused");

    // Answer arrives exactly one cycle into the access phase
    property p_apb;
        @(posedge clk) disable iff (reset)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb timing wrong");

endmodule

`default_nettype wire

// [verif/vsd_detect_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "vsd_params.svh"

module vsd_detect_tb;

    // ************************************************
    // Signals and bench state
    // ************************************************
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, er, got;
    vsd_pkg::vsd_sample_s smp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] dip_live, expd, msk;
    logic [23:0] x;
    logic [23:0] thr [4];
    logic [22:0] win [4];
    longint sum [4];
    int n_fail, checks_done, nwin, off;
    // Hand-made corner case: equal is no dip, full negative scale
    logic [23:0] fx [4] = '{24'h10_0000, 24'h10_0000, 24'hF0_0000, 24'h80_0000};
    logic [23:0] fthr [4] = '{24'h20_0000, 24'h20_0001, 24'h20_0001, 24'hFF_FFFF};

    vsd_detect vsd_detect_i (.clk(clk), .reset(reset), .sample(smp), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .dip_live(dip_live),
        .irq(irq));

    // Free running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ************************************************
    // Tasks and expectation functions
    // ************************************************
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; answer is judged where pready is settled
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        got = 1'b0;
        for (int k = 0; k < 20 && !got; k++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                got = 1'b1;
                rd = prdata;
                er = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!got) begin
            check("apb_pready", 32'h0000_0000, 32'h0000_0001);
            print_verdict();
        end
    endtask

    function automatic longint mag(input logic [23:0] v);
        return v[23] ? (longint'(1) << 24) - longint'(v) : longint'(v);
    endfunction

    function automatic logic dip(input longint s, input logic [23:0] t, input int n);
        return (2 * s) < (longint'(t) * n);
    endfunction

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        void'($urandom(32'h90ec731e));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        smp = '0;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // Reset values of every register
        for (int c = 0; c < 4; c++) begin
            apb(1'b0, 8'(c * 16), 32'h0000_0000);
            check("win_reset", rd, 32'h0000_0000);
            check("slverr_ok", 32'(er), 32'h0000_0000);
            apb(1'b0, 8'(c * 16 + 4), 32'h0000_0000);
            check("thr_reset", rd, 32'h0000_0000);
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(`VSD_IDX_STATUS * 4 + i * 4), 32'h0000_0000);
            check("flag_reset", rd, 32'h0000_0000);
        end
        // Field widths: window top bit reads zero
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'(c * 16), 32'hFFFF_FFFF);
            apb(1'b0, 8'(c * 16), 32'h0000_0000);
            check("win_width", rd, 32'h007F_FFFF);
            apb(1'b1, 8'(c * 16 + 4), 32'hFFFF_FFFF);
            apb(1'b0, 8'(c * 16 + 4), 32'h0000_0000);
            check("thr_width", rd, 32'h00FF_FFFF);
        end
        // Unmapped and unaligned places are refused
        foreach (fx[i]) begin
            apb(1'b0, (i % 2 == 0) ? 8'h4C : 8'h02, 32'h0000_0000);
            check("slverr_bad", 32'(er), 32'h0000_0001);
            check("rdata_bad", rd, 32'h0000_0000);
        end
        // Detection trials, one channel often disabled
        for (int t = 0; t < 10; t++) begin
            nwin = (t == 0) ? 1 : 1 + $urandom % 4;
            off = (t == 0) ? 4 : $urandom % 5;
            msk = 4'($urandom);
            for (int c = 0; c < 4; c++) begin
                win[c] = (c == off) ? 23'h00_0000 : 23'(nwin);
                thr[c] = (t == 0) ? fthr[c] : 24'($urandom);
                sum[c] = 0;
                apb(1'b1, 8'(c * 16), 32'(win[c]));
                apb(1'b1, 8'(c * 16 + 4), 32'(thr[c]));
            end
            apb(1'b1, 8'(`VSD_IDX_MASK * 4), 32'(msk));
            apb(1'b0, 8'(`VSD_IDX_MASK * 4), 32'h0000_0000);
            check("mask", rd, 32'(msk));
            apb(1'b1, 8'(`VSD_IDX_STATUS * 4), 32'h0000_000F);
            apb(1'b0, 8'(`VSD_IDX_STATUS * 4), 32'h0000_0000);
            check("status_clear", rd, 32'h0000_0000);
            for (int i = 0; i < nwin; i++) begin
                @(posedge clk);
                smp.valid <= 1'b1;
                for (int c = 0; c < 4; c++) begin
                    x = (t == 0) ? fx[c] : 24'($urandom);
                    smp.data[c] <= x;
                    sum[c] += mag(x);
                end
            end
            @(posedge clk);
            smp.valid <= 1'b0;
            for (int c = 0; c < 4; c++) begin
                expd[c] = (win[c] != 0) && dip(sum[c], thr[c], nwin);
            end
            repeat (3) @(posedge clk);
            @(negedge clk);
            check("dip_voltage", {dip_live[2], dip_live[0]}, {expd[2], expd[0]});
            check("dip_current", {dip_live[3], dip_live[1]}, {expd[3], expd[1]});
            check("irq", 32'(irq), 32'(|(expd & msk)));
            apb(1'b0, 8'(`VSD_IDX_LIVE * 4), 32'h0000_0000);
            check("live_reg", rd, 32'(expd));
            apb(1'b0, 8'(`VSD_IDX_STATUS * 4), 32'h0000_0000);
            check("status", rd, 32'(expd));
        end
        print_verdict();
    end

endmodule

`default_nettype wire
